// ---- rtl/pmd_map.vh ----
// register offsets, field positions, reset values and timing counts
// for the peripheral module disable controller; definitions only
`ifndef PMD_MAP_VH
`define PMD_MAP_VH

// register byte offsets on the register port
`define PMD_OFF_CTRL0    16'h010c
`define PMD_OFF_CTRL1    16'h010d
`define PMD_OFF_READY0   16'h0111
`define PMD_OFF_READY1   16'h0112
`define PMD_OFF_BLOCKED  16'h0113

// reset values
`define PMD_CTRL_RESET   8'h00
`define PMD_ZERO_BYTE    8'h00

// module_disable_ctrl_0 bit positions
`define PMD_B_TIMER_ZERO     7
`define PMD_B_CLOCK_REF      6
`define PMD_B_PIN_CHANGE     5
`define PMD_B_ACTIVE_TUNING  4
`define PMD_B_CLOCK_NET      3
`define PMD_B_MEM_SCANNER    2
`define PMD_B_CHECKSUM       1
`define PMD_B_NVM_ACCESS     0

// module_disable_ctrl_1 bit positions (vector index minus 8)
`define PMD_B_PULSE_MOD_ONE  7
`define PMD_B_CAPCMP_TWO     6
`define PMD_B_CAPCMP_ONE     5
`define PMD_B_TIMER_SIX      4
`define PMD_B_TIMER_FOUR     3
`define PMD_B_TIMER_TWO      2
`define PMD_B_TIMER_THREE    1
`define PMD_B_TIMER_ONE      0

// blocked-access status bit positions
`define PMD_B_BLK_WRITE      0
`define PMD_B_BLK_READ       1

// settle time after re-enable, in instruction cycles
`define PMD_CLKS_PER_INSTR   4
`define PMD_SETTLE_INSTR     2
`define PMD_SETTLE_CYC       (`PMD_SETTLE_INSTR * `PMD_CLKS_PER_INSTR)

`endif

// ---- rtl/pmd_chan.v ----
// one peripheral channel: reset hold, settle wait and output gating
// assumes off comes from a flop in clk domain and ce gates all state
`timescale 1ns/1ps
module pmd_chan #(
  parameter SETTLE_CYC = 8,
  parameter CNT_W      = 4
)(
  input  wire clk,        // system clock
  input  wire reset_n,    // async reset, active low
  input  wire ce,         // clock enable
  input  wire off,        // disable bit of this peripheral
  input  wire out_raw,    // raw output of the peripheral
  output reg  chan_rst_n, // peripheral reset, active low
  output reg  chan_ready, // peripheral enabled and settled
  output reg  chan_out    // gated peripheral output
);

  localparam [2:0] ST_ON     = 3'b001;
  localparam [2:0] ST_OFF    = 3'b010;
  localparam [2:0] ST_SETTLE = 3'b100;
  localparam [31:0]      LAST_W   = SETTLE_CYC - 1;
  localparam [CNT_W-1:0] CNT_LAST = LAST_W[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};

  reg [2:0]       state;
  reg [2:0]       next_state;
  reg [CNT_W-1:0] cnt;
  reg [CNT_W-1:0] next_cnt;

  always @*
  begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ST_ON:
      begin
        if (off)
          next_state = ST_OFF;
      end
      ST_OFF:
      begin
        next_cnt = {CNT_W{1'b0}};
        if (!off)
          next_state = ST_SETTLE;
      end
      ST_SETTLE:
      begin
        if (off)
          next_state = ST_OFF;
        else if (cnt == CNT_LAST)
          next_state = ST_ON;
        else
          next_cnt = cnt + CNT_ONE;
      end
      default:
        next_state = ST_OFF;
    endcase
  end

  // release out of reset leaves the peripheral at its power-on values
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state      <= ST_ON;
      cnt        <= {CNT_W{1'b0}};
      chan_rst_n <= 1'b0;
      chan_ready <= 1'b0;
      chan_out   <= 1'b0;
    end
    else if (ce)
    begin
      state      <= next_state;
      cnt        <= next_cnt;
      chan_rst_n <= (next_state != ST_OFF);
      chan_ready <= (next_state == ST_ON);
      chan_out   <= out_raw & ~off & (state != ST_OFF);
    end
  end

endmodule

// ---- rtl/pmd_ctrl.v ----
// peripheral module disable controller: two disable registers, per
// peripheral reset hold, special-function register gating and output
// gating; assumes the system address decode drives sfr_hit one-hot
// and the owning peripheral drives sfr_rdata in the strobe cycle
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "pmd_map.vh"
module pmd_ctrl #(
  parameter ADDR_W     = 16,
  parameter N_PERIPH   = 16,
  parameter SETTLE_CYC = `PMD_SETTLE_CYC,
  parameter CNT_W      = 4
)(
  input  wire                clk,            // system clock
  input  wire                reset_n,        // async reset, active low
  input  wire                ce,             // clock enable
  input  wire [ADDR_W-1:0]   addr,           // register port address
  input  wire [7:0]          wdata,          // register port write data
  input  wire                wr,             // write strobe
  input  wire                rd,             // read strobe
  output reg  [7:0]          rdata,          // read data, cycle after rd
  input  wire [N_PERIPH-1:0] sfr_hit,        // owner of addressed sfr
  input  wire [7:0]          sfr_rdata,      // owner read data
  output reg  [N_PERIPH-1:0] sfr_wr,         // gated sfr write strobes
  output reg  [N_PERIPH-1:0] sfr_rd,         // gated sfr read strobes
  output reg  [ADDR_W-1:0]   sfr_addr,       // sfr address, delayed
  output reg  [7:0]          sfr_wdata,      // sfr write data, delayed
  input  wire [N_PERIPH-1:0] periph_out_raw, // raw peripheral outputs
  output wire [N_PERIPH-1:0] periph_out,     // gated peripheral outputs
  output wire [N_PERIPH-1:0] periph_rst_n,   // peripheral resets
  output wire [N_PERIPH-1:0] periph_ready,   // enabled and settled
  output reg                 periph_system_clock_freq_en, // full-rate clock enable
  input  wire                nvm_rd_req,     // memory read request
  input  wire                nvm_wr_req,     // memory write request
  output reg                 nvm_rd_go,      // gated memory read
  output reg                 nvm_wr_go       // gated memory write
);

  reg  [7:0]          module_disable_ctrl_0;
  reg  [7:0]          module_disable_ctrl_1;
  reg  [1:0]          blocked;
  wire [15:0]         module_disable_ctrl_n;
  wire                own_sel;
  wire                sfr_open;
  wire                sfr_shut;
  reg  [7:0]          next_rdata;
  reg  [1:0]          next_blocked;

  function is_reg;
    input [ADDR_W-1:0] a;
    input [15:0]       off;
    begin
      is_reg = (a == off[ADDR_W-1:0]);
    end
  endfunction

  // index 0..7 is control 0, index 8..15 is control 1
  assign module_disable_ctrl_n = {module_disable_ctrl_1,
                                  module_disable_ctrl_0};

  assign own_sel = is_reg(addr, `PMD_OFF_CTRL0) |
                   is_reg(addr, `PMD_OFF_CTRL1) |
                   is_reg(addr, `PMD_OFF_READY0) |
                   is_reg(addr, `PMD_OFF_READY1) |
                   is_reg(addr, `PMD_OFF_BLOCKED);

  // an sfr access passes only when its owner is enabled and settled
  assign sfr_open = ~own_sel & |(sfr_hit & periph_ready);
  assign sfr_shut = ~own_sel & |sfr_hit & ~sfr_open;

  // disable registers are never gated by the channels they steer
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      module_disable_ctrl_0 <= `PMD_CTRL_RESET;
      module_disable_ctrl_1 <= `PMD_CTRL_RESET;
    end
    else if (ce && wr)
    begin
      if (is_reg(addr, `PMD_OFF_CTRL0))
        module_disable_ctrl_0 <= wdata;
      if (is_reg(addr, `PMD_OFF_CTRL1))
        module_disable_ctrl_1 <= wdata;
    end
  end

  // sticky record of accesses refused by a peripheral not enabled and settled;
  // write one to clear, a new refusal in the same cycle wins
  always @*
  begin
    next_blocked = blocked;
    if (wr && is_reg(addr, `PMD_OFF_BLOCKED))
      next_blocked = blocked & ~wdata[1:0];
    if (wr && sfr_shut)
      next_blocked[`PMD_B_BLK_WRITE] = 1'b1;
    if (rd && sfr_shut)
      next_blocked[`PMD_B_BLK_READ] = 1'b1;
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      blocked <= 2'h0;
    else if (ce)
      blocked <= next_blocked;
  end

  // read path: own registers first, then the owning peripheral
  always @*
  begin
    next_rdata = `PMD_ZERO_BYTE;
    if (is_reg(addr, `PMD_OFF_CTRL0))
      next_rdata = module_disable_ctrl_0;
    else if (is_reg(addr, `PMD_OFF_CTRL1))
      next_rdata = module_disable_ctrl_1;
    else if (is_reg(addr, `PMD_OFF_READY0))
      next_rdata = periph_ready[7:0];
    else if (is_reg(addr, `PMD_OFF_READY1))
      next_rdata = periph_ready[15:8];
    else if (is_reg(addr, `PMD_OFF_BLOCKED))
      next_rdata = {6'h00, blocked};
    else if (sfr_open)
      next_rdata = sfr_rdata;
    else
      next_rdata = `PMD_ZERO_BYTE;
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata <= `PMD_ZERO_BYTE;
    else if (ce)
    begin
      if (rd)
        rdata <= next_rdata;
      else
        rdata <= `PMD_ZERO_BYTE;
    end
  end

  // forwarded sfr strobes lag the port by one cycle; the trade keeps
  // every output on a flop at the cost of one cycle of write latency
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sfr_wr    <= {N_PERIPH{1'b0}};
      sfr_rd    <= {N_PERIPH{1'b0}};
      sfr_addr  <= {ADDR_W{1'b0}};
      sfr_wdata <= `PMD_ZERO_BYTE;
    end
    else if (ce)
    begin
      sfr_addr  <= addr;
      sfr_wdata <= wdata;
      if (wr && !own_sel)
        sfr_wr <= sfr_hit & periph_ready;
      else
        sfr_wr <= {N_PERIPH{1'b0}};
      if (rd && !own_sel)
        sfr_rd <= sfr_hit & periph_ready;
      else
        sfr_rd <= {N_PERIPH{1'b0}};
    end
  end

  // quarter-rate clocked peripherals do not use this enable
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      periph_system_clock_freq_en <= 1'b0;
      nvm_rd_go      <= 1'b0;
      nvm_wr_go      <= 1'b0;
    end
    else if (ce)
    begin
      periph_system_clock_freq_en <= ~module_disable_ctrl_0[`PMD_B_CLOCK_NET];
      nvm_rd_go <= nvm_rd_req &
                   ~module_disable_ctrl_0[`PMD_B_NVM_ACCESS];
      nvm_wr_go <= nvm_wr_req &
                   ~module_disable_ctrl_0[`PMD_B_NVM_ACCESS];
    end
  end

  // the settle wait also shields software that skips the pause
  genvar g;
  generate
    for (g = 0; g < N_PERIPH; g = g + 1)
    begin : chan
      pmd_chan #(
        .SETTLE_CYC (SETTLE_CYC),
        .CNT_W      (CNT_W)
      ) u_chan (
        .clk        (clk),
        .reset_n    (reset_n),
        .ce         (ce),
        .off        (module_disable_ctrl_n[g]),
        .out_raw    (periph_out_raw[g]),
        .chan_rst_n (periph_rst_n[g]),
        .chan_ready (periph_ready[g]),
        .chan_out   (periph_out[g])
      );
    end
  endgenerate

endmodule

// ---- tb/pmd_ctrl_sva.sv ----
// checker for the module disable controller, top ports only
// assumes one system clock and its async active-low reset
`timescale 1ns/1ps
`include "pmd_map.vh"
module pmd_chk (
  input wire        clk,            // system clock
  input wire        reset_n,        // async reset, active low
  input wire        ce,             // clock enable
  input wire [15:0] addr,           // register address
  input wire [7:0]  wdata,          // write data
  input wire        wr,             // write strobe
  input wire        rd,             // read strobe
  input wire [7:0]  rdata,          // read data
  input wire [15:0] sfr_hit,        // sfr owner
  input wire [15:0] sfr_wr,         // gated sfr writes
  input wire [15:0] periph_out,     // gated outputs
  input wire [15:0] periph_rst_n,   // peripheral resets
  input wire [15:0] periph_ready,   // settled flags
  input wire        periph_system_clock_freq_en, // full-rate clock enable
  input wire        nvm_rd_req,     // memory read request
  input wire        nvm_rd_go       // gated memory read
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  out_off_a: assert property ((periph_out & ~periph_rst_n) == 16'h0)
    else $error("output live while held");
  ready_hold_a: assert property ((periph_ready & ~periph_rst_n) == 16'h0)
    else $error("ready while held");
  hold_on_set_a: assert property (ce && wr && addr == `PMD_OFF_CTRL1
    && wdata[0] ##1 ce |=> !periph_rst_n[8] && !periph_out[8])
    else $error("peripheral not held after set");
  clk_net_a: assert property (ce && wr && addr == `PMD_OFF_CTRL0
    ##1 !wr && ce
    |=> periph_system_clock_freq_en == !$past(wdata[3], 2))
    else $error("clock enable wrong");
  nvm_cause_a: assert property (nvm_rd_go && $past(ce)
    |-> $past(nvm_rd_req))
    else $error("memory read without request");
  rd_idle_a: assert property ($past(ce) && !$past(rd) |-> rdata == 8'h00)
    else $error("read data outside slot");
  sfr_block_a: assert property (ce && wr && addr > 16'h0113
    && (sfr_hit & ~periph_ready) != 16'h0 |=> sfr_wr == 16'h0)
    else $error("write reached disabled peripheral");
  sfr_pass_a: assert property (ce && wr && addr > 16'h0113
    && (sfr_hit & periph_ready) != 16'h0 |=> sfr_wr == $past(sfr_hit))
    else $error("write to enabled peripheral lost");
  sfr_cause_a: assert property (sfr_wr != 16'h0 && $past(ce)
    |-> $past(wr))
    else $error("stray sfr write");
  settle_time_a: assert property ($rose(periph_ready[8])
    && $past(reset_n, 9) |-> $past(periph_rst_n[8], 8))
    else $error("ready too soon after enable");
endmodule
bind pmd_ctrl pmd_chk i_chk (.clk(clk), .reset_n(reset_n), .ce(ce),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .sfr_hit(sfr_hit), .sfr_wr(sfr_wr), .periph_out(periph_out),
  .periph_rst_n(periph_rst_n), .periph_ready(periph_ready),
  .periph_system_clock_freq_en(periph_system_clock_freq_en), .nvm_rd_req(nvm_rd_req),
  .nvm_rd_go(nvm_rd_go));

// ---- tb/peripheral_module_disable_test.sv ----
// self-checking bench for the module disable controller
// assumes the bench is the only register master and sfr decoder
`timescale 1ns/1ps
`include "pmd_map.vh"
module peripheral_module_disable_test;
  reg         clk = 0, reset_n = 0, ce = 1, wr = 0, rd = 0;
  reg  [15:0] addr = 0, sfr_hit = 0;
  reg  [7:0]  wdata = 0;
  reg         nvm_rd_req = 0, nvm_wr_req = 0;
  wire [7:0]  rdata, sfr_wdata;
  wire [15:0] sfr_wr, sfr_rd, sfr_addr, periph_out, periph_rst_n;
  wire [15:0] periph_ready;
  wire        periph_system_clock_freq_en, nvm_rd_go, nvm_wr_go;
  integer     mismatches = 0, samples_checked = 0, n;
  always #12.5 clk = ~clk;
  pmd_ctrl i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sfr_hit(sfr_hit),
    .sfr_rdata(8'h3c), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .periph_out_raw(16'hffff), .periph_out(periph_out),
    .periph_rst_n(periph_rst_n), .periph_ready(periph_ready),
    .periph_system_clock_freq_en(periph_system_clock_freq_en), .nvm_rd_req(nvm_rd_req),
    .nvm_wr_req(nvm_wr_req), .nvm_rd_go(nvm_rd_go),
    .nvm_wr_go(nvm_wr_go));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr_reg(input [15:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a; wdata <= d; wr <= 1;
      @(posedge clk);
      wr <= 0;
    end
  endtask
  // data stands only in the cycle after the strobe, so look just then
  task rd_reg(input [15:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      addr <= a; rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 chk(rdata, exp);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task t_reset;
    begin
      chk(periph_rst_n, 16'hffff);
      chk(periph_ready, 16'hffff);
      chk(periph_system_clock_freq_en, 1);
      rd_reg(`PMD_OFF_CTRL0, 8'h00);
      rd_reg(`PMD_OFF_CTRL1, 8'h00);
      $display("reset test done");
    end
  endtask
  task t_regs;
    begin
      wr_reg(`PMD_OFF_CTRL0, 8'ha4);
      wr_reg(`PMD_OFF_CTRL1, 8'h5a);
      rd_reg(`PMD_OFF_CTRL0, 8'ha4);
      rd_reg(`PMD_OFF_CTRL1, 8'h5a);
      rd_reg(16'h0200, 8'h00);
      chk(periph_rst_n, 16'ha55b);
      chk(periph_out, 16'ha55b);
      chk(periph_system_clock_freq_en, 1);
      wr_reg(`PMD_OFF_CTRL0, 8'h08);
      wr_reg(`PMD_OFF_CTRL1, 8'h00);
      #1 chk(periph_system_clock_freq_en, 0);
      $display("register test done");
    end
  endtask
  task t_nvm;
    begin
      wr_reg(`PMD_OFF_CTRL0, 8'h01);
      nvm_rd_req <= 1; nvm_wr_req <= 1;
      repeat (2) @(posedge clk);
      #1 chk({nvm_rd_go, nvm_wr_go}, 0);
      // index 0 owns the memory control registers
      sfr_hit <= 16'h0001;
      wr_reg(16'h0500, 8'h55);
      #1 chk(sfr_wr, 16'h0000);
      sfr_hit <= 16'h0000;
      wr_reg(`PMD_OFF_CTRL0, 8'h00);
      repeat (2) @(posedge clk);
      #1 chk({nvm_rd_go, nvm_wr_go}, 3);
      @(posedge clk);
      nvm_rd_req <= 0; nvm_wr_req <= 0;
      $display("memory test done");
    end
  endtask
  task t_sfr;
    begin
      wr_reg(`PMD_OFF_CTRL1, 8'h01);
      sfr_hit <= 16'h0100;
      wr_reg(16'h0400, 8'h77);
      #1 chk(sfr_wr, 0);
      rd_reg(16'h0400, 8'h00);
      rd_reg(`PMD_OFF_BLOCKED, 8'h03);
      rd_reg(`PMD_OFF_READY0, 8'hff);
      rd_reg(`PMD_OFF_READY1, 8'hfe);
      wr_reg(`PMD_OFF_BLOCKED, 8'h03);
      rd_reg(`PMD_OFF_BLOCKED, 8'h00);
      wr_reg(`PMD_OFF_CTRL1, 8'h00);
      n = 0;
      @(posedge clk);
      #1 chk(periph_rst_n[8], 1);
      // software must not touch the peripheral until it has settled
      while (periph_ready[8] !== 1'b1 && n < 40)
      begin
        @(posedge clk);
        #1 n = n + 1;
      end
      chk(n, `PMD_SETTLE_CYC);
      wr_reg(16'h0400, 8'h77);
      #1 chk(sfr_wr, 16'h0100);
      chk(sfr_wdata, 8'h77);
      chk(sfr_addr, 16'h0400);
      rd_reg(16'h0400, 8'h3c);
      chk(sfr_rd, 16'h0100);
      sfr_hit <= 16'h0000;
      $display("sfr test done");
    end
  endtask
  task t_misc;
    begin
      @(posedge clk);
      ce <= 0;
      wr_reg(`PMD_OFF_CTRL0, 8'hff);
      ce <= 1;
      rd_reg(`PMD_OFF_CTRL0, 8'h00);
      wr_reg(`PMD_OFF_CTRL0, 8'hff);
      reset_n <= 0;
      repeat (3) @(posedge clk);
      reset_n <= 1;
      repeat (2) @(posedge clk);
      #1 t_reset;
      $display("second reset test done");
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1;
    repeat (2) @(posedge clk);
    #1 t_reset;
    t_regs;
    t_nvm;
    t_sfr;
    t_misc;
    complete_run;
  end
  // whole run needs about a hundred cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    mismatches = mismatches + 1;
    complete_run;
  end
endmodule
